// [hdl/rx_cond_pkg.sv]
// constants for the receive timeslot conditioning block
package rx_cond_pkg;
   localparam int ADDR_W = 8;
   localparam int SLOTS = 32;
   // indirect register map
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] CTRL_LAST = 8'h1F;
   localparam logic [7:0] CODE_BASE = 8'h20;
   localparam logic [7:0] CODE_LAST = 8'h3F;
   localparam logic [7:0] SIG_LO_FIRST = 8'h41;
   localparam logic [7:0] SIG_LO_LAST = 8'h4F;
   localparam logic [7:0] SIG_HI_FIRST = 8'h51;
   localparam logic [7:0] SIG_HI_LAST = 8'h5F;
   localparam logic [7:0] SIG_BASE = 8'h40;
   localparam logic [7:0] GLOBAL_CFG = 8'h60;
   localparam logic [7:0] STATE_STAT = 8'h61;
   // slot control fields
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;
   localparam int MSB_INV_BIT = 4;
   localparam int ODD_INV_BIT = 3;
   localparam int EVEN_INV_BIT = 2;
   localparam int LSB_SUPP_BIT = 1;
   localparam int SLOT_SUPP_BIT = 0;
   // signaling code fields
   localparam int SIG_EN_BIT = 4;
   localparam int SIG_W = 5;
   // global config fields
   localparam int GSEL_MSB = 2;
   localparam int CLK_MASTER_BIT = 4;
   localparam int GATE_EN_BIT = 5;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam logic [4:0] SIG_RESET_VAL = 5'h00;
   // inversion masks, bit 1 of the slot is byte bit 7
   localparam logic [7:0] MASK_EVEN = 8'h55;
   localparam logic [7:0] MASK_ODD = 8'h2A;
   localparam logic [7:0] MASK_MSB = 8'h80;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] LAST_SLOT = 5'h1F;
   localparam logic [4:0] SIG_SLOT = 5'h10;
   localparam logic [4:0] FAS_SLOT = 5'h00;

   typedef enum logic [2:0] {
      SEL_PASS = 3'b000,
      SEL_CODE = 3'b001,
      SEL_ALAW = 3'b010,
      SEL_ULAW = 3'b011
   } replace_sel_e;

   // digital milliwatt sequences, frame n byte sits at bits 8n+7:8n
   localparam logic [63:0] ALAW_MW = 64'hB4A1_A1B4_3421_2134;
   localparam logic [63:0] ULAW_MW = 64'h9E8B_8B9E_1E0B_0B1E;
endpackage : rx_cond_pkg

// [hdl/slot_timing_if.sv]
// bit and slot position shared between the conditioning modules
interface slot_timing_if;
   logic strobe;
   logic rx_bit;
   logic [2:0] bit_idx;
   logic [4:0] slot_idx;
   logic [2:0] frame_idx;
   logic slot_end;
   modport src (output strobe, rx_bit, bit_idx, slot_idx, frame_idx,
      slot_end);
   modport dst (input strobe, rx_bit, bit_idx, slot_idx, frame_idx,
      slot_end);
endinterface : slot_timing_if

// [hdl/slot_timing.sv]
// bit, slot and frame counters for the receive stream
module slot_timing
   import rx_cond_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic rx_bit_en,
   input wire logic rx_frame_sync,
   input wire logic rx_data,
   slot_timing_if.src tm
);
   logic [2:0] bit_q;
   logic [4:0] slot_q;
   logic [2:0] frame_q;
   logic [2:0] cur_bit;
   logic [4:0] cur_slot;

   // frame sync forces the current bit to bit 1 of slot 0
   assign cur_bit = rx_frame_sync ? 3'h0 : bit_q;
   assign cur_slot = rx_frame_sync ? FAS_SLOT : slot_q;

   assign tm.strobe = rx_bit_en;
   assign tm.rx_bit = rx_data;
   assign tm.bit_idx = cur_bit;
   assign tm.slot_idx = cur_slot;
   assign tm.frame_idx = frame_q;
   assign tm.slot_end = rx_bit_en && (cur_bit == LAST_BIT);

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         bit_q <= 3'h0;
         slot_q <= 5'h00;
      end
      else if (rx_bit_en)
      begin
         bit_q <= cur_bit + 3'h1;
         if (cur_bit == LAST_BIT)
            slot_q <= cur_slot + 5'h01;
         else
            slot_q <= cur_slot;
      end
   end

   // frame count picks the milliwatt byte, wraps every eight frames
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         frame_q <= 3'h0;
      else if (rx_bit_en && cur_bit == LAST_BIT && cur_slot == LAST_SLOT)
         frame_q <= frame_q + 3'h1;
   end
endmodule : slot_timing

// [hdl/byte_conditioner.sv]
// replacement, signaling code and inversion for one timeslot byte
module byte_conditioner
   import rx_cond_pkg::*;
(
   input wire logic [7:0] raw_byte,
   input wire logic [7:0] slot_ctrl,
   input wire logic [7:0] slot_code,
   input wire logic [4:0] slot_sig,
   input wire logic [2:0] global_sel,
   input wire logic [2:0] frame_idx,
   output logic [7:0] out_byte
);
   logic [2:0] sel;
   logic [7:0] repl;
   logic [7:0] sigd;
   logic [7:0] inv_mask;

   always_comb
   begin
      sel = (global_sel != SEL_PASS) ? global_sel
         : slot_ctrl[SEL_MSB:SEL_LSB];
      case (sel)
         SEL_CODE: repl = slot_code;
         SEL_ALAW: repl = ALAW_MW[{frame_idx, 3'b000} +: 8];
         SEL_ULAW: repl = ULAW_MW[{frame_idx, 3'b000} +: 8];
         default: repl = raw_byte;
      endcase
      // signaling code into the low nibble
      sigd = slot_sig[SIG_EN_BIT] ? {repl[7:4], slot_sig[3:0]} : repl;
      inv_mask = (slot_ctrl[EVEN_INV_BIT] ? MASK_EVEN : 8'h00)
         | (slot_ctrl[ODD_INV_BIT] ? MASK_ODD : 8'h00)
         | (slot_ctrl[MSB_INV_BIT] ? MASK_MSB : 8'h00);
      out_byte = sigd ^ inv_mask;
   end
endmodule : byte_conditioner

// [hdl/e1_rx_timeslot_conditioning.sv]
// receive timeslot payload conditioning top with register port
module e1_rx_timeslot_conditioning
   import rx_cond_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic rx_data,
   input wire logic rx_bit_en,
   input wire logic rx_frame_sync,
   output logic sys_rx_data,
   output logic sys_rx_clk,
   output logic sys_rx_frame_sync
);
   slot_timing_if tm ();

   logic [7:0] ctrl_mem [SLOTS];
   logic [7:0] code_mem [SLOTS];
   logic [4:0] sig_mem [SLOTS];
   logic [7:0] gcfg_q;
   logic [7:0] rdata_q;
   logic [6:0] shift_q;
   logic [7:0] hold_q;
   logic [7:0] hold_ctrl_q;
   logic [4:0] hold_slot_q;
   logic hold_valid_q;
   logic data_q;
   logic clk_q;
   logic fs_q;
   logic [7:0] cond_byte;
   logic [7:0] rdata_d;
   logic gate_active;
   logic bit_gated;

   function automatic logic is_ctrl(input logic [7:0] a);
      return a <= CTRL_LAST;
   endfunction : is_ctrl

   function automatic logic is_code(input logic [7:0] a);
      return a >= CODE_BASE && a <= CODE_LAST;
   endfunction : is_code

   // slots 0 and 16 carry no signaling code register
   function automatic logic is_sig(input logic [7:0] a);
      return (a >= SIG_LO_FIRST && a <= SIG_LO_LAST)
         || (a >= SIG_HI_FIRST && a <= SIG_HI_LAST);
   endfunction : is_sig

   slot_timing u_timing (
      .mclk(mclk),
      .rstn(rstn),
      .rx_bit_en(rx_bit_en),
      .rx_frame_sync(rx_frame_sync),
      .rx_data(rx_data),
      .tm(tm.src)
   );

   byte_conditioner u_cond (
      .raw_byte({shift_q, tm.rx_bit}),
      .slot_ctrl(ctrl_mem[tm.slot_idx]),
      .slot_code(code_mem[tm.slot_idx]),
      .slot_sig(sig_mem[tm.slot_idx]),
      .global_sel(gcfg_q[GSEL_MSB:0]),
      .frame_idx(tm.frame_idx),
      .out_byte(cond_byte)
   );

   // per-slot register arrays
   for (genvar i = 0; i < SLOTS; i++)
   begin : g_slot
      always_ff @(posedge mclk)
      begin
         if (!rstn)
         begin
            ctrl_mem[i] <= RESET_VAL;
            code_mem[i] <= RESET_VAL;
            sig_mem[i] <= SIG_RESET_VAL;
         end
         else if (reg_wr)
         begin
            if (is_ctrl(reg_addr) && reg_addr[4:0] == 5'(i))
               ctrl_mem[i] <= reg_wdata;
            if (is_code(reg_addr) && reg_addr[4:0] == 5'(i))
               code_mem[i] <= reg_wdata;
            if (is_sig(reg_addr) && reg_addr[4:0] == 5'(i))
               sig_mem[i] <= reg_wdata[SIG_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         gcfg_q <= RESET_VAL;
      else if (reg_wr && reg_addr == GLOBAL_CFG)
         gcfg_q <= reg_wdata;
   end

   always_comb
   begin
      rdata_d = 8'h00;
      if (is_ctrl(reg_addr))
         rdata_d = ctrl_mem[reg_addr[4:0]];
      else if (is_code(reg_addr))
         rdata_d = code_mem[reg_addr[4:0]];
      else if (is_sig(reg_addr))
         rdata_d = {3'b000, sig_mem[reg_addr[4:0]]};
      else if (reg_addr == GLOBAL_CFG)
         rdata_d = gcfg_q;
      else if (reg_addr == STATE_STAT)
         rdata_d = {hold_valid_q, 2'b00, hold_slot_q};
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (reg_rd)
         rdata_q <= rdata_d;
      else
         rdata_q <= 8'h00;
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         shift_q <= 7'h00;
      else if (tm.strobe)
         shift_q <= {shift_q[5:0], tm.rx_bit};
   end

   // one slot of latency: a byte must be whole before it is replaced
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         hold_q <= 8'h00;
         hold_ctrl_q <= 8'h00;
         hold_slot_q <= 5'h00;
         hold_valid_q <= 1'b0;
      end
      else if (tm.slot_end)
      begin
         hold_q <= cond_byte;
         hold_ctrl_q <= ctrl_mem[tm.slot_idx];
         hold_slot_q <= tm.slot_idx;
         hold_valid_q <= 1'b1;
      end
   end

   // gating only as clock master with gating enabled
   assign gate_active = gcfg_q[CLK_MASTER_BIT] && gcfg_q[GATE_EN_BIT];
   // whole slot wins over bit 8 only
   assign bit_gated = gate_active && (hold_ctrl_q[SLOT_SUPP_BIT]
      || (hold_ctrl_q[LSB_SUPP_BIT] && tm.bit_idx == LAST_BIT));

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         data_q <= 1'b0;
         clk_q <= 1'b0;
         fs_q <= 1'b0;
      end
      else
      begin
         if (tm.strobe)
            data_q <= hold_q[3'(LAST_BIT - tm.bit_idx)];
         clk_q <= tm.strobe && hold_valid_q && !bit_gated;
         fs_q <= tm.strobe && hold_valid_q && tm.bit_idx == 3'h0
            && hold_slot_q == FAS_SLOT;
      end
   end

   assign reg_rdata = rdata_q;
   assign sys_rx_data = data_q;
   assign sys_rx_clk = clk_q;
   assign sys_rx_frame_sync = fs_q;
endmodule : e1_rx_timeslot_conditioning

// [verif/e1_rx_timeslot_conditioning_properties.sv]
// port-level checks for the receive timeslot conditioning block
module rx_cond_properties
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic rx_data,
   input wire logic rx_bit_en,
   input wire logic rx_frame_sync,
   input wire logic sys_rx_data,
   input wire logic sys_rx_clk,
   input wire logic sys_rx_frame_sync
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   logic [7:0] g_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // output starts with the ninth strobe, one full slot in
   always_ff @(posedge mclk)
      if (!rstn) cnt_q <= 4'h0;
      else if (rx_bit_en && cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
   always_ff @(posedge mclk)
      if (!rstn) g_q <= 8'h00;
      else if (reg_wr && reg_addr == 8'h60) g_q <= reg_wdata;
   rdata_quiet_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside answer cycle");
   unmapped_zero_a: assert property ($past(reg_rd &&
      (reg_addr == 8'h40 || reg_addr == 8'h50)) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   sig_upper_a: assert property (
      $past(reg_rd && reg_addr[7:5] == 3'h2 && reg_addr[3:0] != 4'h0)
      |-> reg_rdata[7:5] == 3'h0)
      else $error("signaling upper bits set");
   clk_cause_a: assert property (sys_rx_clk || sys_rx_frame_sync
      |-> $past(rx_bit_en)) else $error("clock without strobe");
   data_hold_a: assert property (
      !$past(rx_bit_en) |-> $stable(sys_rx_data))
      else $error("data moved between bits");
   ungated_clk_a: assert property ($past(rx_bit_en) && cnt_q > 4'h8 &&
      g_q[5:4] != 2'h3 |-> sys_rx_clk) else $error("clock gated wrongly");
   fs_clk_a: assert property (sys_rx_frame_sync && g_q[5:4] != 2'h3
      |-> sys_rx_clk) else $error("frame sync without clock");
   reset_quiet_a: assert property (disable iff (1'b0) !$past(rstn)
      |-> !sys_rx_clk && !sys_rx_frame_sync && reg_rdata == 8'h00)
      else $error("output active in reset");
   cover property (sys_rx_frame_sync);
   cover property ($past(rx_bit_en) && cnt_q > 4'h8 && !sys_rx_clk);
   cover property ($past(reg_rd) && reg_rdata != 8'h00);
endmodule : rx_cond_properties

bind e1_rx_timeslot_conditioning rx_cond_properties u_props (.mclk, .rstn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_data, .rx_bit_en,
   .rx_frame_sync, .sys_rx_data, .sys_rx_clk, .sys_rx_frame_sync);

// [verif/backplane_sink.sv]
// backplane sink: gathers bits on each clock pulse into slot bytes
module backplane_sink
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ser_data,
   input wire logic ser_clk,
   input wire logic ser_fs,
   output logic [7:0] slot_byte [32],
   output logic [8:0] frame_pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pos_q, p;
   logic [8:0] cnt_q;
   logic [7:0] sh_q;
   // only clocked bits count, so gapped bits shift positions
   always @(posedge mclk)
   begin
      p = ser_fs ? 8'h00 : pos_q;
      if (ser_clk) sh_q <= {sh_q[6:0], ser_data};
      if (ser_clk && p[2:0] == 3'h7) slot_byte[p[7:3]] <= {sh_q[6:0], ser_data};
      if (ser_clk) pos_q <= p + 8'h01;
      if (ser_clk) cnt_q <= ser_fs ? 9'h001 : cnt_q + 9'h001;
      if (ser_clk && ser_fs) frame_pulses <= cnt_q;
      if (!rstn) pos_q <= 8'h00;
      if (!rstn) cnt_q <= 9'h000;
      if (!rstn) frame_pulses <= 9'h000;
   end
endmodule : backplane_sink

// [verif/e1_rx_timeslot_conditioning_bench.sv]
// self-checking bench for the receive timeslot conditioning block
module e1_rx_timeslot_conditioning_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic rx_data = 1'b0, rx_bit_en = 1'b0, rx_frame_sync = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic sys_rx_data, sys_rx_clk, sys_rx_frame_sync;
   logic [7:0] slot_byte [32];
   logic [8:0] frame_pulses;
   int err_count = 0, checked = 0, cycles = 0;
   // frame 1 uses global mu-law so the frame index of the pattern is seen
   logic [7:0] gcfg [4] = '{8'h00, 8'h13, 8'h30, 8'h30};
   logic [7:0] ctl [32] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'hE0, 8'h04,
      8'h08, 8'h10, 8'h1C, 8'h0C, 8'h14, 8'h18, 8'h3C, 8'h02, 8'h03, 8'h00,
      8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   initial forever #12.5 mclk = ~mclk;
   e1_rx_timeslot_conditioning DUT (.mclk, .rstn, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .rx_data, .rx_bit_en, .rx_frame_sync,
      .sys_rx_data, .sys_rx_clk, .sys_rx_frame_sync);
   backplane_sink u_sink (.mclk, .rstn, .ser_data(sys_rx_data),
      .ser_clk(sys_rx_clk), .ser_fs(sys_rx_frame_sync), .slot_byte,
      .frame_pulses);
   task automatic conclude();
      if (err_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000) err_count = err_count + 1;
      if (cycles == 20000) conclude();
   end
   task automatic chk(input string what, input logic [8:0] e, logic [8:0] g);
      checked++;
      if (g !== e) $display("wrong value %s expected %h seen %h", what, e, g);
      if (g !== e) err_count++;
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk("register read", {1'b0, e}, {1'b0, reg_rdata});
   endtask : rd
   function automatic logic [7:0] code(int s);
      return 8'hC3 ^ 8'(s);
   endfunction : code
   function automatic logic [7:0] raw(int s, int f);
      return 8'h5A ^ 8'(s * 8 + f);
   endfunction : raw
   function automatic logic [7:0] want(int s, int f);
      logic [2:0] sel;
      logic [7:0] b;
      sel = (gcfg[f][2:0] != 3'h0) ? gcfg[f][2:0] : ctl[s][7:5];
      b = raw(s, f);
      if (sel == 3'h1) b = code(s);
      if (sel == 3'h2) b = f ? 8'h21 : 8'h34;
      if (sel == 3'h3) b = f ? 8'h0B : 8'h1E;
      if (s == 5) b[3:0] = 4'hA;
      // the three groups are disjoint, so xor equals their union
      return b ^ (ctl[s][4] ? 8'h80 : 8'h00) ^ (ctl[s][3] ? 8'h2A : 8'h00)
         ^ (ctl[s][2] ? 8'h55 : 8'h00);
   endfunction : want
   task automatic send_slot(input int s, input int f);
      logic [7:0] b;
      b = raw(s, f);
      for (int k = 7; k >= 0; k--)
      begin
         @(posedge mclk);
         rx_bit_en <= 1'b1;
         rx_data <= b[k];
         rx_frame_sync <= (s == 0 && k == 7);
         @(posedge mclk);
         rx_bit_en <= 1'b0;
         rx_frame_sync <= 1'b0;
      end
      // let the last bit reach the sink before anyone looks
      repeat (2) @(posedge mclk);
      #1;
   endtask : send_slot
   initial
   begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      rd(8'h05, 8'h00);
      rd(8'h25, 8'h00);
      rd(8'h45, 8'h00);
      rd(8'h61, 8'h00);
      wr(8'h40, 8'hFF);
      wr(8'h50, 8'hFF);
      rd(8'h40, 8'h00);
      rd(8'h50, 8'h00);
      wr(8'h5F, 8'hFF);
      rd(8'h5F, 8'h1F);
      wr(8'h5F, 8'h00);
      wr(8'h45, 8'h1A);
      for (int s = 0; s < 32; s++) wr(8'(s), ctl[s]);
      for (int s = 0; s < 32; s++) wr(8'(8'h20 + s), code(s));
      rd(8'h0D, 8'h3C);
      rd(8'h3F, code(31));
      for (int f = 0; f < 4; f++)
         for (int s = 0; s < 32 && !(f == 3 && s > 1); s++)
         begin
            if (s == 0) wr(8'h60, gcfg[f]);
            send_slot(s, f);
            if (s == 0 && f > 1) chk("pulses", 9'h100, frame_pulses);
            if (s == 0 && f > 0 && f < 3)
               for (int t = 0; t < 32; t++)
                  chk("slot byte", {1'b0, want(t, f - 1)},
                     {1'b0, slot_byte[t]});
         end
      chk("gapped pulses", 9'h0EF, frame_pulses);
      rd(8'h60, 8'h30);
      rd(8'h61, 8'h81);
      conclude();
   end
endmodule : e1_rx_timeslot_conditioning_bench
